// >>> pkg/mcc_pkg.sv
// Functional notes
// - Lamp test lights every panel indicator except margin, power-status and roller groups.
// - Transfer at repeat reads control word keyed on address keys 8-19; F00 gives ones.
// - Control-store data register holds bits 0-99 with odd parity; F02 gives zeroes.
// - Main store writes data keys at keyed address; display reads back into S and T.
// - A correct main store with check control at stop leaves check-register-2 off.
// - Local store and display use data keys 32-63; the result shows in T.
// - Set instruction counter loads address keys plus eight with odd byte parity.
// - While running with timer switch at mid, the timer decrements in A bits 00-23.
// - Timer disable switch down stops the interval timer decrementing.
// - Instruction-step rate runs one instruction per start press, then halts.
// - Single-cycle rate advances one micro-cycle per start press.
// - Main display loads S, T, A and B, with odd parity on each byte.
// - Main-byte store modifies only the byte selected by the low address bits.
// - Storage-inhibit cycle rate writes local store with zero data and parity, flagging errors.
// - With check control at stop, any error that sets check-register-2 (storage parity or hardware) forces a hard stop, indications held.
`default_nettype none
package mcc_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_DKEY_HI = 8'h00;
  localparam logic [7:0] OFS_DKEY_LO = 8'h04;
  localparam logic [7:0] OFS_AKEY = 8'h08;
  localparam logic [7:0] OFS_SWITCH = 8'h0C;
  localparam logic [7:0] OFS_BUTTON = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFS_REG_S = 8'h20;
  localparam logic [7:0] OFS_REG_T = 8'h24;
  localparam logic [7:0] OFS_REG_A = 8'h28;
  localparam logic [7:0] OFS_REG_B = 8'h2C;
  localparam logic [7:0] OFS_IC = 8'h30;
  localparam logic [7:0] OFS_CSAR = 8'h34;
  localparam logic [7:0] OFS_FLAGS = 8'h38;
  localparam logic [7:0] OFS_BYTE_PAR = 8'h3C;
  localparam logic [7:0] OFS_CSDR0 = 8'h40;
  localparam logic [7:0] OFS_CSDR1 = 8'h44;
  localparam logic [7:0] OFS_CSDR2 = 8'h48;
  localparam logic [7:0] OFS_CSDR3 = 8'h4C;
  // Button register bit positions.
  localparam int BTN_RESET = 0;
  localparam int BTN_TRANSFER = 1;
  localparam int BTN_STORE = 2;
  localparam int BTN_DISPLAY = 3;
  localparam int BTN_SET_IC = 4;
  localparam int BTN_START = 5;
  localparam int BTN_STOP = 6;
  // Interrupt status bit positions.
  localparam int EV_STORE = 0;
  localparam int EV_DISPLAY = 1;
  localparam int EV_TRANSFER = 2;
  localparam int EV_STEP = 3;
  localparam int EV_ERROR = 4;
  localparam int EV_HARD_STOP = 5;
  localparam int EV_W = 6;
  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EV_W-1:0] RST_EV = 6'h00;
  localparam logic [23:0] RST_IC = 24'h000000;
  localparam logic [11:0] RST_CSAR = 12'h000;
  // Fixed words of the control store and the counter offset.
  localparam logic [11:0] CS_ALL_ONES = 12'hF00;
  localparam logic [11:0] CS_ALL_ZERO = 12'hF02;
  localparam logic [23:0] IC_SET_OFFSET = 24'h000008;
  // Interval timer tick period.
  localparam int TIMER_TICK_NS = 3300;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_TICK_CYC = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Storage sizes.
  localparam int MS_WORDS = 256;
  localparam int LS_REGS = 16;
  // Rate switch and storage select encodings.
  typedef enum logic [1:0] {
    RATE_PROCESS = 2'h0,
    RATE_INSTRUCTION_STEP_RATE = 2'h1,
    RATE_CYCLE = 2'h2,
    RATE_CYCLE_INHIBIT = 2'h3
  } mcc_rate_t;
  typedef enum logic [1:0] {
    SEL_MAIN = 2'h0,
    SEL_LOCAL = 2'h1,
    SEL_MAIN_BYTE = 2'h2,
    SEL_SPARE = 2'h3
  } mcc_sel_t;
  // Switch register layout, bit 7 downward.
  typedef struct packed {
    logic lamp_test;
    logic timer_down;
    logic cs_repeat;
    logic check_stop;
    mcc_sel_t stor_sel;
    mcc_rate_t rate;
  } mcc_switch_t;
  localparam logic [7:0] RST_SWITCH = 8'h00;
  // Panel indicators.
  typedef struct packed {
    logic margin;
    logic power;
    logic roller;
    logic system;
    logic manual;
    logic test;
    logic check2;
    logic ls_par;
    logic cs_par;
    logic hard_stop;
  } mcc_lamps_t;
  // Requests toward the processor.
  typedef struct packed {
    logic run;
    logic step_insn;
    logic step_cycle;
    logic inhibit_store;
  } mcc_proc_req_t;
endpackage : mcc_pkg
`default_nettype wire

// >>> rtl/mcc_odd_par.sv
`default_nettype none
// Single odd-parity bit over a word of any width.
module mcc_odd_par #(
  parameter int W = 8
) (
  input wire logic [W-1:0] data_i,
  output logic par_o
);
  // The bit makes the total count of ones odd.
  assign par_o = ~^data_i;
endmodule : mcc_odd_par
`default_nettype wire

// >>> rtl/mcc_byte_par.sv
`default_nettype none
// Odd parity for each byte of a word; byte 0 is the most significant.
module mcc_byte_par #(
  parameter int NB = 4
) (
  input wire logic [8*NB-1:0] data_i,
  output logic [NB-1:0] par_o
);
  // One parity bit per byte, bit order follows byte order.
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      par_o[NB-1-i] = ~^data_i[8*(NB-1-i) +: 8];
    end
  end
endmodule : mcc_byte_par
`default_nettype wire

// >>> rtl/mcc_console.sv
`default_nettype none
// Manual console: keys and switches over Wishbone, storage paths, stepping and indicators.
module mcc_console (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output mcc_pkg::mcc_lamps_t lamps_o,
  output mcc_pkg::mcc_proc_req_t proc_req_o,
  input wire logic insn_done_i,
  input wire logic cycle_done_i,
  input wire logic [11:0] csar_i,
  input wire logic ic_load_i,
  input wire logic [23:0] ic_next_i,
  input wire logic hw_error_i
);
  import mcc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STEP = 3'b100
  } mcc_state_t;

  logic [63:0] dkey, next_dkey;
  logic [23:0] akey, next_akey;
  mcc_switch_t sw, next_sw;
  logic [6:0] btn;
  logic [EV_W-1:0] ev_stat, next_ev_stat, ev_en, next_ev_en, ev_set;
  logic [31:0] reg_s, reg_t, reg_a, reg_b, next_s, next_t, next_a, next_b;
  logic [3:0] par_s, par_t, par_a, par_b, next_par_s, next_par_t, next_par_a, next_par_b;
  logic [23:0] ic, next_ic;
  logic [2:0] par_ic, next_par_ic;
  logic [11:0] csar, next_csar;
  logic [99:0] csdr, next_csdr;
  logic csdr_par, next_csdr_par;
  logic f_check2, f_ls_par, f_cs_par, f_hard;
  logic next_check2, next_ls_par, next_cs_par, next_hard;
  mcc_state_t state, next_state;
  mcc_proc_req_t next_req;
  logic [15:0] tick, next_tick;
  logic [31:0] next_rdata;
  logic next_ack, bus_wr;
  logic [71:0] ms [MS_WORDS];
  logic [35:0] ls [LS_REGS];
  logic ms_we, ls_we;
  logic [71:0] ms_wdata, ms_rd;
  logic [35:0] ls_wdata, ls_rd;
  logic [7:0] dkey_par;
  logic [3:0] a_dec_par;
  logic [2:0] ic_gen_par;
  logic cs_gen_par;
  logic [99:0] cs_word;
  logic [23:0] ic_in;
  logic [31:0] a_dec;
  logic [7:0] ms_idx;
  logic [3:0] ls_idx;
  logic [2:0] byte_idx;
  logic timer_go;

  // Parity for keyed data, decremented timer, counter and control words.
  mcc_byte_par #(.NB(8)) u_dkey_par (.data_i(dkey), .par_o(dkey_par));
  mcc_byte_par #(.NB(4)) u_a_par (.data_i(a_dec), .par_o(a_dec_par));
  mcc_byte_par #(.NB(3)) u_ic_par (.data_i(ic_in), .par_o(ic_gen_par));
  mcc_odd_par #(.W(100)) u_cs_par (.data_i(cs_word), .par_o(cs_gen_par));

  // Storage addressing and array reads.
  assign ms_idx = akey[10:3];
  assign ls_idx = akey[3:0];
  assign byte_idx = akey[2:0];
  assign ms_rd = ms[ms_idx];
  assign ls_rd = ls[ls_idx];
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  // Control word: fixed ones and zeroes words, others repeat the address.
  always_comb begin
    cs_word = {{8{akey[15:4]}}, akey[15:12]};
    if (akey[15:4] == CS_ALL_ONES) begin
      cs_word = {100{1'b1}};
    end else if (akey[15:4] == CS_ALL_ZERO) begin
      cs_word = {100{1'b0}};
    end
  end

  // Timer decrement in A bits 00-23 and the counter source.
  assign a_dec = {reg_a[31:8] - 24'h000001, reg_a[7:0]};
  assign timer_go = (state == ST_RUN) && !sw.timer_down && (tick == 16'(TIMER_TICK_CYC - 1));
  assign ic_in = (btn[BTN_SET_IC] && state != ST_RUN) ? akey[23:0] + IC_SET_OFFSET : ic_next_i;

  // Wishbone slave: key, switch and enable registers, button pulses and read data.
  always_comb begin
    next_dkey = dkey;
    next_akey = akey;
    next_sw = sw;
    next_ev_en = ev_en;
    btn = 7'h00;
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    if (bus_wr && wb_sel_i == 4'hF) begin
      unique case (wb_adr_i)
        OFS_DKEY_HI: next_dkey[63:32] = wb_dat_i;
        OFS_DKEY_LO: next_dkey[31:0] = wb_dat_i;
        OFS_AKEY: next_akey = wb_dat_i[23:0];
        OFS_SWITCH: next_sw = mcc_switch_t'(wb_dat_i[7:0]);
        OFS_BUTTON: btn = wb_dat_i[6:0];
        OFS_IRQ_EN: next_ev_en = wb_dat_i[EV_W-1:0];
        default: next_ev_en = ev_en;
      endcase
    end
    unique case (wb_adr_i)
      OFS_DKEY_HI: next_rdata = dkey[63:32];
      OFS_DKEY_LO: next_rdata = dkey[31:0];
      OFS_AKEY: next_rdata = {8'h00, akey};
      OFS_SWITCH: next_rdata = {24'h000000, sw};
      OFS_IRQ_STAT: next_rdata = {26'h0000000, ev_stat};
      OFS_IRQ_EN: next_rdata = {26'h0000000, ev_en};
      OFS_REG_S: next_rdata = reg_s;
      OFS_REG_T: next_rdata = reg_t;
      OFS_REG_A: next_rdata = reg_a;
      OFS_REG_B: next_rdata = reg_b;
      OFS_IC: next_rdata = {5'h00, par_ic, ic};
      OFS_CSAR: next_rdata = {20'h00000, csar};
      OFS_FLAGS: next_rdata = {26'h0000000, state == ST_RUN, state == ST_STEP, f_hard, f_cs_par, f_ls_par, f_check2};
      OFS_BYTE_PAR: next_rdata = {16'h0000, par_s, par_t, par_a, par_b};
      OFS_CSDR0: next_rdata = csdr[31:0];
      OFS_CSDR1: next_rdata = csdr[63:32];
      OFS_CSDR2: next_rdata = csdr[95:64];
      OFS_CSDR3: next_rdata = {27'h0000000, csdr_par, csdr[99:96]};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dkey <= {RST_WORD, RST_WORD};
      akey <= RST_IC;
      sw <= mcc_switch_t'(RST_SWITCH);
      ev_en <= RST_EV;
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      dkey <= next_dkey;
      akey <= next_akey;
      sw <= next_sw;
      ev_en <= next_ev_en;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // Store and display paths, counter, control store and error flags.
  always_comb begin
    next_s = reg_s;
    next_t = reg_t;
    next_a = reg_a;
    next_b = reg_b;
    next_par_s = par_s;
    next_par_t = par_t;
    next_par_a = par_a;
    next_par_b = par_b;
    next_ic = ic;
    next_par_ic = par_ic;
    next_csar = csar;
    next_csdr = csdr;
    next_csdr_par = csdr_par;
    next_check2 = f_check2;
    next_ls_par = f_ls_par;
    next_cs_par = f_cs_par;
    ms_we = 1'b0;
    ms_wdata = {dkey, dkey_par};
    ls_we = 1'b0;
    ls_wdata = {dkey[31:0], dkey_par[3:0]};
    ev_set = RST_EV;
    if (btn[BTN_RESET]) begin
      next_check2 = 1'b0;
      next_ls_par = 1'b0;
      next_cs_par = 1'b0;
    end
    if (sw.rate == RATE_CYCLE_INHIBIT) begin
      ls_wdata = 36'h0_0000_0000;
    end
    if (btn[BTN_STORE] && state != ST_RUN) begin
      ev_set[EV_STORE] = 1'b1;
      unique case (sw.stor_sel)
        SEL_LOCAL: ls_we = 1'b1;
        SEL_MAIN_BYTE: begin
          ms_we = 1'b1;
          ms_wdata = ms_rd;
          ms_wdata[8+8*(7-byte_idx) +: 8] = dkey[8*(7-byte_idx) +: 8];
          ms_wdata[7-byte_idx] = dkey_par[7-byte_idx];
        end
        default: ms_we = 1'b1;
      endcase
    end else if (btn[BTN_DISPLAY] && state != ST_RUN) begin
      ev_set[EV_DISPLAY] = 1'b1;
      if (sw.stor_sel == SEL_LOCAL) begin
        next_t = ls_rd[35:4];
        next_par_t = ls_rd[3:0];
        for (int i = 0; i < 4; i++) begin
          if (^{ls_rd[4+8*i +: 8], ls_rd[i]} == 1'b0) begin
            next_ls_par = 1'b1;
            next_check2 = 1'b1;
          end
        end
      end else begin
        next_s = ms_rd[71:40];
        next_t = ms_rd[39:8];
        next_a = ms_rd[71:40];
        next_b = ms_rd[39:8];
        next_par_s = ms_rd[7:4];
        next_par_t = ms_rd[3:0];
        next_par_a = ms_rd[7:4];
        next_par_b = ms_rd[3:0];
        for (int i = 0; i < 8; i++) begin
          if (^{ms_rd[8+8*i +: 8], ms_rd[i]} == 1'b0) begin
            next_check2 = 1'b1;
          end
        end
      end
    end else if (btn[BTN_TRANSFER] && sw.cs_repeat && state != ST_RUN) begin
      ev_set[EV_TRANSFER] = 1'b1;
      next_csdr = cs_word;
      next_csdr_par = cs_gen_par;
      next_csar = akey[15:4];
      next_cs_par = f_cs_par | (^{cs_word, cs_gen_par} == 1'b0);
    end else if (timer_go) begin
      next_a = a_dec;
      next_par_a = a_dec_par;
    end
    if ((btn[BTN_SET_IC] && state != ST_RUN) || ic_load_i) begin
      next_ic = ic_in;
      next_par_ic = ic_gen_par;
    end
    if (cycle_done_i) begin
      next_csar = csar_i;
    end
    if (hw_error_i) begin
      next_check2 = 1'b1;
    end
    ev_set[EV_ERROR] = (next_check2 && !f_check2) || hw_error_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_s <= RST_WORD;
      reg_t <= RST_WORD;
      reg_a <= RST_WORD;
      reg_b <= RST_WORD;
      par_s <= 4'hF;
      par_t <= 4'hF;
      par_a <= 4'hF;
      par_b <= 4'hF;
      ic <= RST_IC;
      par_ic <= 3'h7;
      csar <= RST_CSAR;
      csdr <= {100{1'b0}};
      csdr_par <= 1'b1;
      f_check2 <= 1'b0;
      f_ls_par <= 1'b0;
      f_cs_par <= 1'b0;
    end else begin
      reg_s <= next_s;
      reg_t <= next_t;
      reg_a <= next_a;
      reg_b <= next_b;
      par_s <= next_par_s;
      par_t <= next_par_t;
      par_a <= next_par_a;
      par_b <= next_par_b;
      ic <= next_ic;
      par_ic <= next_par_ic;
      csar <= next_csar;
      csdr <= next_csdr;
      csdr_par <= next_csdr_par;
      f_check2 <= next_check2;
      f_ls_par <= next_ls_par;
      f_cs_par <= next_cs_par;
    end
  end

  // Storage arrays hold data with one odd-parity bit per byte.
  always_ff @(posedge clk_i) begin
    if (ms_we) begin
      ms[ms_idx] <= ms_wdata;
    end
    if (ls_we) begin
      ls[ls_idx] <= ls_wdata;
    end
  end

  // Run and step sequencing, hard stop and the interval tick.
  always_comb begin
    next_state = state;
    next_req = '0;
    next_hard = f_hard && !btn[BTN_RESET];
    next_tick = (state == ST_RUN && tick != 16'(TIMER_TICK_CYC - 1)) ? tick + 16'h0001 : 16'h0000;
    unique case (state)
      ST_IDLE: begin
        if (btn[BTN_START] && !f_hard) begin
          unique case (sw.rate)
            RATE_PROCESS: next_state = ST_RUN;
            RATE_INSTRUCTION_STEP_RATE: begin
              next_state = ST_STEP;
              next_req.step_insn = 1'b1;
            end
            default: begin
              next_state = ST_STEP;
              next_req.step_cycle = 1'b1;
            end
          endcase
        end
      end
      ST_RUN: begin
        if (btn[BTN_STOP] || btn[BTN_RESET]) begin
          next_state = ST_IDLE;
        end
      end
      ST_STEP: begin
        if (insn_done_i || cycle_done_i || btn[BTN_RESET]) begin
          next_state = ST_IDLE;
        end
      end
    endcase
    if ((hw_error_i || next_check2) && sw.check_stop) begin
      next_hard = 1'b1;
      next_state = ST_IDLE;
      next_req = '0;
    end
    next_req.run = next_state == ST_RUN;
    next_req.inhibit_store = sw.rate == RATE_CYCLE_INHIBIT;
    next_ev_stat = (ev_stat & ~((bus_wr && wb_adr_i == OFS_IRQ_CLR) ? wb_dat_i[EV_W-1:0] : RST_EV)) | ev_set;
    next_ev_stat[EV_STEP] = next_ev_stat[EV_STEP] | (state == ST_STEP && next_state == ST_IDLE);
    next_ev_stat[EV_HARD_STOP] = next_ev_stat[EV_HARD_STOP] | (next_hard && !f_hard);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      proc_req_o <= '0;
      f_hard <= 1'b0;
      tick <= 16'h0000;
      ev_stat <= RST_EV;
    end else begin
      state <= next_state;
      proc_req_o <= next_req;
      f_hard <= next_hard;
      tick <= next_tick;
      ev_stat <= next_ev_stat;
    end
  end

  // Interrupt and lamp outputs; lamp test spares the excluded groups.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      lamps_o <= '0;
    end else begin
      irq_o <= |(next_ev_stat & ev_en);
      lamps_o.margin <= 1'b0;
      lamps_o.power <= 1'b0;
      lamps_o.roller <= 1'b0;
      lamps_o.system <= sw.lamp_test || next_state == ST_RUN;
      lamps_o.manual <= sw.lamp_test || next_state != ST_RUN;
      lamps_o.test <= sw.lamp_test || sw.rate != RATE_PROCESS || sw.check_stop || sw.cs_repeat || sw.timer_down;
      lamps_o.check2 <= sw.lamp_test || next_check2;
      lamps_o.ls_par <= sw.lamp_test || next_ls_par;
      lamps_o.cs_par <= sw.lamp_test || next_cs_par;
      lamps_o.hard_stop <= sw.lamp_test || next_hard;
    end
  end
endmodule : mcc_console
`default_nettype wire

// >>> verification/mcc_console_assertions.sv
`default_nettype none
// Bus, stepping, stop and reset relations at the console ports.
module mcc_console_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire mcc_pkg::mcc_lamps_t lamps_o,
  input wire mcc_pkg::mcc_proc_req_t proc_req_o,
  input wire logic insn_done_i,
  input wire logic cycle_done_i,
  input wire logic hw_error_i
);
  import mcc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A bus request, or any source of an event.
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic cause = req || insn_done_i || cycle_done_i || hw_error_i;
  sequence req_s;
    req && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_once_a: assert property (req_s |=> ack_pulse_s)
    else $error("ack not a single pulse");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without a request");
  reset_quiet_a: assert property ($fell(rst_i) |-> lamps_o == '0 && proc_req_o == '0 && !irq_o && !wb_ack_o)
    else $error("outputs not quiet after reset");
  insn_pulse_a: assert property (proc_req_o.step_insn |=> !proc_req_o.step_insn)
    else $error("long instruction step request");
  cycle_pulse_a: assert property (proc_req_o.step_cycle |=> !proc_req_o.step_cycle)
    else $error("long micro-cycle step request");
  step_excl_a: assert property (!(proc_req_o.step_insn && proc_req_o.step_cycle))
    else $error("both step kinds requested");
  stop_halts_a: assert property ($rose(lamps_o.hard_stop) |=> !proc_req_o.run)
    else $error("runs after a hard stop");
  stop_held_a: assert property ($fell(lamps_o.hard_stop) || $fell(lamps_o.check2) |->
    $past(req, 1) || $past(req, 2) || $past(req, 3))
    else $error("error indication dropped unasked");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(cause, 1) || $past(cause, 2) || $past(cause, 3))
    else $error("interrupt without an event");
  run_cause_a: assert property ($rose(proc_req_o.run) |-> $past(req, 1) || $past(req, 2) || $past(req, 3))
    else $error("run without a start press");
endmodule // mcc_console_assertions
bind mcc_console mcc_console_assertions mcc_console_assertions_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .irq_o, .lamps_o, .proc_req_o, .insn_done_i, .cycle_done_i, .hw_error_i);
`default_nettype wire

// >>> verification/mcc_proc_model.sv
`default_nettype none
// Processor stand-in: answers each step request after a settable delay.
module mcc_proc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mcc_pkg::mcc_proc_req_t proc_req_i,
  input wire logic [3:0] delay_i,
  input wire logic err_i,
  output logic insn_done_o,
  output logic cycle_done_o,
  output logic ic_load_o,
  output logic [11:0] csar_o,
  output logic [23:0] ic_next_o,
  output logic hw_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;
  localparam logic [11:0] SEQ [4] = '{12'h21C, 12'h107, 12'h724, 12'h9AE};
  int cnt;
  logic insn;
  logic loop;
  logic [1:0] idx;
  initial {insn_done_o, cycle_done_o, ic_load_o, hw_error_o, csar_o, ic_next_o} = '0;
  // Unqualified buses toggle, so stale values never pass as answers.
  always @(posedge clk_i) begin
    insn_done_o <= 1'b0;
    cycle_done_o <= 1'b0;
    ic_load_o <= 1'b0;
    csar_o <= ~csar_o;
    ic_next_o <= ~ic_next_o;
    hw_error_o <= err_i;
    if (rst_i) begin
      cnt <= 0;
      loop <= 1'b0;
      idx <= 2'h0;
    end else if (proc_req_i.step_insn || proc_req_i.step_cycle) begin
      cnt <= int'(delay_i) + 1;
      insn <= proc_req_i.step_insn;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1 && insn) begin
        insn_done_o <= 1'b1;
        ic_load_o <= 1'b1;
        ic_next_o <= loop ? 24'h0000F0 : 24'h000000;
        loop <= ~loop;
      end else if (cnt == 1) begin
        cycle_done_o <= 1'b1;
        csar_o <= SEQ[idx];
        idx <= idx + 2'h1;
      end
    end
  end
endmodule // mcc_proc_model
`default_nettype wire

// >>> verification/mcc_console_tb.sv
`default_nettype none
// Drives the console over Wishbone; reads are checked against queued notes.
module mcc_console_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } mcc_note_t;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, err = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF, dly = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, d1, hi, lo;
  logic wb_ack_o, irq_o, insn_done_i, cycle_done_i, ic_load_i, hw_error_i;
  logic [11:0] csar_i;
  logic [23:0] ic_next_i;
  mcc_lamps_t lamps_o;
  mcc_proc_req_t proc_req_o;
  mcc_note_t notes[$];
  mcc_note_t nt;
  int n_errors = 0, compares = 0, seed = 57;
  localparam logic [11:0] SEQ [4] = '{12'h21C, 12'h107, 12'h724, 12'h9AE};
  mcc_console mcc_console_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .lamps_o, .proc_req_o, .insn_done_i, .cycle_done_i,
    .csar_i, .ic_load_i, .ic_next_i, .hw_error_i);
  mcc_proc_model mcc_proc_model_i (.clk_i, .rst_i, .proc_req_i(proc_req_o), .delay_i(dly), .err_i(err),
    .insn_done_o(insn_done_i), .cycle_done_o(cycle_done_i), .ic_load_o(ic_load_i), .csar_o(csar_i),
    .ic_next_o(ic_next_i), .hw_error_o(hw_error_i));
  // Free-running 100 MHz clock.
  initial forever #5 clk_i = ~clk_i;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= w;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k == 20) begin
      check(32'h0, 32'h1);
      conclude();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    bus(1'b1, a, w, d1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic btn(input int b);
    wr(OFS_BUTTON, 32'h1 << b);
  endtask
  // Waits for the step interrupt, then clears all status.
  task automatic wait_irq;
    int k;
    for (k = 0; k < 200 && irq_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 200) begin
      check(32'h0, 32'h1);
      conclude();
    end
    wr(OFS_IRQ_CLR, 32'h3F);
  endtask
  function automatic logic [3:0] bpar(input logic [31:0] w);
    for (int i = 0; i < 4; i++) bpar[i] = ~^w[8*i+:8];
  endfunction
  // Each read answer is compared with the oldest note.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      nt = notes.pop_front();
      check(wb_dat_o & nt.m, nt.e & nt.m);
    end
  end
  // Switch word: lamp test 80, timer down 40, repeat 20, check stop 10, select 0C, rate 03.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_IC, 32'h07000000);
    rd(OFS_BYTE_PAR, 32'h0000FFFF);
    rd(OFS_CSDR3, 32'h10);
    rd(8'h50, 32'h0);
    wr(OFS_SWITCH, 32'h80);
    repeat (2) @(posedge clk_i);
    check(32'(lamps_o), 32'h7F);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_SWITCH, i < 2 ? 32'h20 : 32'h0);
      wr(OFS_AKEY, i == 1 ? 32'h00F020 : 32'h00F000);
      btn(BTN_TRANSFER);
      rd(OFS_CSDR0, i == 0 ? 32'hFFFFFFFF : 32'h0);
      rd(OFS_CSDR2, i == 0 ? 32'hFFFFFFFF : 32'h0);
      rd(OFS_CSDR3, i == 0 ? 32'h1F : 32'h10);
      rd(OFS_CSAR, i == 0 ? 32'hF00 : 32'hF02);
      rd(OFS_FLAGS, 32'h0, 32'h4);
    end
    wr(OFS_SWITCH, 32'h10);
    wr(OFS_IRQ_EN, 32'h3);
    for (int i = 0; i < 2; i++) begin
      hi = i ? $random(seed) : 32'h0F0F0F0F;
      lo = i ? $random(seed) : 32'hF0F0F0F0;
      wr(OFS_DKEY_HI, hi);
      wr(OFS_DKEY_LO, lo);
      wr(OFS_AKEY, i ? 32'h18 : 32'h0);
      btn(BTN_STORE);
      rd(OFS_FLAGS, 32'h0, 32'h1);
      btn(BTN_DISPLAY);
      rd(OFS_REG_S, hi);
      rd(OFS_REG_T, lo);
      rd(OFS_REG_A, hi);
      rd(OFS_REG_B, lo);
      rd(OFS_BYTE_PAR, {16'h0, bpar(hi), bpar(lo), bpar(hi), bpar(lo)});
    end
    wr(OFS_AKEY, 32'h0);
    btn(BTN_DISPLAY);
    rd(OFS_REG_S, 32'h0F0F0F0F);
    check({31'h0, irq_o}, 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    rd(OFS_IRQ_STAT, 32'h3, 32'h3);
    check({31'h0, irq_o}, 32'h0);
    wr(OFS_IRQ_CLR, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0, 32'h3);
    wr(OFS_SWITCH, 32'h14);
    wr(OFS_AKEY, 32'h0F);
    wr(OFS_DKEY_LO, 32'h55AA33CC);
    btn(BTN_STORE);
    btn(BTN_DISPLAY);
    rd(OFS_REG_T, 32'h55AA33CC);
    wr(OFS_SWITCH, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_AKEY, i ? 32'h0 : 32'h808080);
      btn(BTN_SET_IC);
      rd(OFS_IC, i ? 32'h06000008 : 32'h01808088);
    end
    hi = 32'hFFFFFFFF;
    wr(OFS_DKEY_HI, hi);
    wr(OFS_DKEY_LO, hi);
    wr(OFS_AKEY, 32'h100);
    btn(BTN_STORE);
    wr(OFS_DKEY_HI, 32'h0);
    wr(OFS_DKEY_LO, 32'h0);
    wr(OFS_SWITCH, 32'h08);
    for (int b = 0; b < 4; b++) begin
      wr(OFS_AKEY, 32'h100 + b);
      btn(BTN_STORE);
      btn(BTN_DISPLAY);
      hi[31-8*b-:8] = 8'h00;
      rd(OFS_REG_S, hi);
      rd(OFS_REG_A, hi);
      rd(OFS_REG_T, 32'hFFFFFFFF);
    end
    wr(OFS_IRQ_EN, 32'h1 << EV_STEP);
    for (int r = 1; r < 3; r++) begin
      wr(OFS_SWITCH, r);
      for (int i = 0; i < 4; i++) begin
        dly <= 4'(i * 3);
        btn(BTN_START);
        wait_irq();
        if (r == 1) rd(OFS_IC, i[0] ? 32'hF0 : 32'h0, 32'hF0);
        else rd(OFS_CSAR, {20'h0, SEQ[i]});
      end
    end
    wr(OFS_SWITCH, 32'h0);
    btn(BTN_START);
    rd(OFS_REG_A, 32'h0, 32'h0);
    d1 = d;
    repeat (700) @(posedge clk_i);
    rd(OFS_REG_A, 32'h0, 32'h0);
    check({31'h0, 24'(d1[31:8] - d[31:8]) inside {700 / TIMER_TICK_CYC, 700 / TIMER_TICK_CYC + 1}}, 32'h1);
    wr(OFS_SWITCH, 32'h40);
    rd(OFS_REG_A, 32'h0, 32'h0);
    hi = d;
    repeat (700) @(posedge clk_i);
    rd(OFS_REG_A, hi);
    btn(BTN_STOP);
    btn(BTN_RESET);
    wr(OFS_SWITCH, 32'h17);
    wr(OFS_DKEY_LO, 32'hFFFFFFFF);
    wr(OFS_AKEY, 32'h1);
    btn(BTN_STORE);
    btn(BTN_DISPLAY);
    rd(OFS_REG_T, 32'h0);
    rd(OFS_FLAGS, 32'hB, 32'hF);
    check(32'({proc_req_o.inhibit_store, lamps_o[3:0]}), 32'h1D);
    btn(BTN_START);
    repeat (3) @(posedge clk_i);
    check({31'h0, proc_req_o.run}, 32'h0);
    btn(BTN_RESET);
    wr(OFS_SWITCH, 32'h10);
    err <= 1'b1;
    repeat (2) @(posedge clk_i);
    err <= 1'b0;
    rd(OFS_FLAGS, 32'h9, 32'hF);
    conclude();
  end
endmodule // mcc_console_tb
`default_nettype wire
